//--- inc/ecc_defs.svh
// Constants for the encoder capture/compare block: offsets, field positions, resets.
// Assumes a plain register port with word addresses; no timing constants are needed.
`ifndef ECC_DEFS_SVH
`define ECC_DEFS_SVH

`define ECC_ADDR_W 16
`define ECC_OFF_CTRL_STATUS 16'hc000
`define ECC_OFF_CAPCMP 16'hc003
`define ECC_OFF_TRIG_CFG 16'hc004
`define ECC_OFF_IRQ_STATUS 16'hc005
`define ECC_OFF_IRQ_MASK 16'hc006
`define ECC_OFF_SW_TRIG 16'hc007

`define ECC_BIT_LATCH_SEL 11
`define ECC_BIT_OUT_EN 12
`define ECC_BIT_OUT_INV 13
`define ECC_BIT_CMP_EQ 16
`define ECC_BIT_CAP_DONE 17

`define ECC_TRIG_COMB_LSB 0
`define ECC_TRIG_FLAG_LSB 4

`define ECC_IRQ_CAPTURE 0
`define ECC_IRQ_COMPARE 1

`define ECC_CTRL_RESET 24'h000000
`define ECC_CMP_RESET 24'h000000
`define ECC_TRIG_RESET 24'h000000

`endif

//--- inc/ecc_pkg.sv
// Types shared by the encoder capture/compare block.
// Assumes ecc_defs.svh is compiled alongside it.
package ecc_pkg;

   // Trigger combination codes.
   typedef enum logic [3:0] {
      ECC_TRIG_SOFT = 4'h0,
      ECC_TRIG_IDX_RISE = 4'h1,
      ECC_TRIG_IDX_FALL = 4'h2,
      ECC_TRIG_FLAG_RISE = 4'h3,
      ECC_TRIG_FLAG_FALL = 4'h4,
      ECC_TRIG_IDX_HI_FLAG_RISE = 4'h5,
      ECC_TRIG_IDX_HI_FLAG_FALL = 4'h6,
      ECC_TRIG_IDX_RISE_FLAG_HI = 4'h7,
      ECC_TRIG_IDX_RISE_FLAG_LO = 4'h8
   } ecc_trig_comb_t;

   // Register bus request.
   typedef struct packed {
      logic [15:0] addr;
      logic [23:0] wdata;
      logic wr;
      logic rd;
   } ecc_bus_req_t;

   // Encoder inputs: counter, index channel and four flag inputs.
   typedef struct packed {
      logic [23:0] count;
      logic index;
      logic [3:0] flags;
   } ecc_enc_in_t;

endpackage

//--- rtl/ecc_capture_compare.sv
// Encoder position capture and position compare with its register port.
// Assumes the encoder counter, index and flags are synchronous to clk and
// that the counter is zeroed only at power-on or reset, outside this block.
`include "ecc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module ecc_capture_compare
   import ecc_pkg::*;
#(
   parameter int CNT_W = 24
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire ecc_bus_req_t bus_req,
   output logic [23:0] bus_rdata,
   input wire ecc_enc_in_t enc_in,
   output logic equal_output_pin,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State.
   logic [23:0] ctrl_reg, ctrl_next;
   logic [CNT_W-1:0] cmp_reg, cmp_next;
   logic [CNT_W-1:0] cap_reg, cap_next;
   logic cap_done_reg, cap_done_next;
   logic eq_latch_reg, eq_latch_next;
   logic [23:0] trig_reg, trig_next;
   logic [1:0] irq_stat_reg, irq_stat_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic index_d_reg, flag_d_reg;
   logic [23:0] rdata_reg, rdata_next;
   logic out_reg, out_next;
   logic eq_d_reg;
   logic index_d_next, flag_d_next, eq_d_next;
   logic cap_take;

   logic wr_ctrl, wr_cmp, wr_trig, wr_istat, wr_imask, wr_swtrig, rd_cap;
   logic flag_now, idx_rise, idx_fall, flg_rise, flg_fall, trig_hit;
   logic eq_now, equal_output_line;
   logic [3:0] trigger_combination_select;
   logic [1:0] trigger_flag_select;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode; the bus never stalls.
   assign wr_ctrl = bus_req.wr && (bus_req.addr == `ECC_OFF_CTRL_STATUS);
   assign wr_cmp = bus_req.wr && (bus_req.addr == `ECC_OFF_CAPCMP);
   assign wr_trig = bus_req.wr && (bus_req.addr == `ECC_OFF_TRIG_CFG);
   assign wr_istat = bus_req.wr && (bus_req.addr == `ECC_OFF_IRQ_STATUS);
   assign wr_imask = bus_req.wr && (bus_req.addr == `ECC_OFF_IRQ_MASK);
   assign wr_swtrig = bus_req.wr && (bus_req.addr == `ECC_OFF_SW_TRIG);
   assign rd_cap = bus_req.rd && (bus_req.addr == `ECC_OFF_CAPCMP);

   ////////////////////////////////////////////////////////////////////////////
   // Trigger selection from the two settings.
   assign trigger_combination_select = trig_reg[`ECC_TRIG_COMB_LSB +: 4];
   assign trigger_flag_select = trig_reg[`ECC_TRIG_FLAG_LSB +: 2];
   assign flag_now = enc_in.flags[trigger_flag_select];
   assign idx_rise = enc_in.index && !index_d_reg;
   assign idx_fall = !enc_in.index && index_d_reg;
   assign flg_rise = flag_now && !flag_d_reg;
   assign flg_fall = !flag_now && flag_d_reg;

   // Unknown codes never trigger, so a bad setting cannot spray captures.
   always_comb begin
      trig_hit = 1'b0;
      case (trigger_combination_select)
         ECC_TRIG_SOFT: trig_hit = wr_swtrig && bus_req.wdata[0];
         ECC_TRIG_IDX_RISE: trig_hit = idx_rise;
         ECC_TRIG_IDX_FALL: trig_hit = idx_fall;
         ECC_TRIG_FLAG_RISE: trig_hit = flg_rise;
         ECC_TRIG_FLAG_FALL: trig_hit = flg_fall;
         ECC_TRIG_IDX_HI_FLAG_RISE: trig_hit = enc_in.index && flg_rise;
         ECC_TRIG_IDX_HI_FLAG_FALL: trig_hit = enc_in.index && flg_fall;
         ECC_TRIG_IDX_RISE_FLAG_HI: trig_hit = idx_rise && flag_now;
         ECC_TRIG_IDX_RISE_FLAG_LO: trig_hit = idx_rise && !flag_now;
         default: trig_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare runs every cycle on the raw counter, which is never offset.
   assign eq_now = (enc_in.count == cmp_reg);
   // Transparent or latched equal signal.
   assign equal_output_line = ctrl_reg[`ECC_BIT_LATCH_SEL] ? eq_latch_reg : eq_now;

   ////////////////////////////////////////////////////////////////////////////
   // Input edge history.
   // The index and the selected flag are held for one clock so that an edge is seen
   // at the first clock that samples the new level. Both histories reset low, the
   // idle level of the pins, so the release of reset never fakes an edge.
   // A change of the flag select can look like a flag edge for one clock; software
   // should change the select only while the trigger code does not use a flag.
   always_comb begin
      index_d_next = enc_in.index;
      flag_d_next = flag_now;
   end

   // History registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index_d_reg <= 1'b0;
         flag_d_reg <= 1'b0;
      end else begin
         index_d_reg <= index_d_next;
         flag_d_reg <= flag_d_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control word.
   // Only the latch select, output enable and invert bits are storage. The two
   // status bits are put together at read time, so a write can never forge them.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = bus_req.wdata & 24'h003800;
      end
   end

   // Control register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `ECC_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare word.
   // Every 24-bit pattern is a legal signed position, so the write is taken whole.
   // The new value is compared from the clock after the write; a count that equals
   // it in the very cycle of the write is judged against the old value.
   always_comb begin
      cmp_next = cmp_reg;
      if (wr_cmp) begin
         cmp_next = bus_req.wdata[CNT_W-1:0];
      end
   end

   // Compare register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_reg <= CNT_W'(`ECC_CMP_RESET);
      end else begin
         cmp_reg <= cmp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger settings.
   // Combination code in the low nibble, flag select above it; the rest reads zero.
   always_comb begin
      trig_next = trig_reg;
      if (wr_trig) begin
         trig_next = bus_req.wdata & 24'h00003f;
      end
   end

   // Trigger setting register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_reg <= `ECC_TRIG_RESET;
      end else begin
         trig_reg <= trig_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture.
   // The count is taken on the very edge that sees the trigger, so the only skew is
   // the sampling of the pins by the clock. While the done flag stands, further
   // triggers are dropped. A read of the capture word re-arms, but a trigger in that
   // same cycle is still dropped, as the done flag clears only at the next edge.
   assign cap_take = trig_hit && !cap_done_reg;

   always_comb begin
      cap_next = cap_reg;
      cap_done_next = cap_done_reg;
      if (rd_cap) begin
         cap_done_next = 1'b0;
      end
      if (cap_take) begin
         cap_next = enc_in.count;
         cap_done_next = 1'b1;
      end
   end

   // Capture registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_reg <= '0;
         cap_done_reg <= 1'b0;
      end else begin
         cap_reg <= cap_next;
         cap_done_reg <= cap_done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Equal latch and output pin.
   // The latch is held clear for as long as the select bit is low, so software
   // clears it by taking the bit low and high again. The pin is registered to keep
   // it free of glitches from the counter compare; the price is one clock of lag.
   always_comb begin
      eq_latch_next = eq_latch_reg;
      if (!ctrl_reg[`ECC_BIT_LATCH_SEL]) begin
         eq_latch_next = 1'b0;
      end else if (eq_now) begin
         eq_latch_next = 1'b1;
      end
      // Gate, then set polarity; a disabled output rests at its inactive level.
      out_next = (equal_output_line && ctrl_reg[`ECC_BIT_OUT_EN])
         ^ ctrl_reg[`ECC_BIT_OUT_INV];
      // History of the selected equal signal, for its rising-edge event.
      eq_d_next = equal_output_line;
   end

   // Equal path registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eq_latch_reg <= 1'b0;
         out_reg <= 1'b0;
         eq_d_reg <= 1'b0;
      end else begin
         eq_latch_reg <= eq_latch_next;
         out_reg <= out_next;
         eq_d_reg <= eq_d_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask.
   // Events are sticky and cleared by writing ones. An event in the same cycle as
   // its clear wins, so an event is never lost to a late clear. The compare event
   // follows the selected equal signal, so a transparent pulse is not missed here.
   always_comb begin
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (wr_imask) begin
         irq_mask_next = bus_req.wdata[1:0];
      end
      if (wr_istat) begin
         irq_stat_next = irq_stat_reg & ~bus_req.wdata[1:0];
      end
      if (cap_take) begin
         irq_stat_next[`ECC_IRQ_CAPTURE] = 1'b1;
      end
      if (equal_output_line && !eq_d_reg) begin
         irq_stat_next[`ECC_IRQ_COMPARE] = 1'b1;
      end
   end

   // Interrupt registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data.
   // Read data stand for the one cycle after the strobe and are zero otherwise, so
   // a master that looks late sees zero rather than stale data. Status bits are
   // sampled in the strobe cycle, the same cycle in which a capture read re-arms.
   always_comb begin
      rdata_next = 24'h000000;
      if (bus_req.rd) begin
         case (bus_req.addr)
            `ECC_OFF_CTRL_STATUS: begin
               rdata_next = ctrl_reg;
               rdata_next[`ECC_BIT_CMP_EQ] = equal_output_line;
               rdata_next[`ECC_BIT_CAP_DONE] = cap_done_reg;
            end
            `ECC_OFF_CAPCMP: rdata_next = 24'(signed'(cap_reg));
            `ECC_OFF_TRIG_CFG: rdata_next = trig_reg;
            `ECC_OFF_IRQ_STATUS: rdata_next = {22'h000000, irq_stat_reg};
            `ECC_OFF_IRQ_MASK: rdata_next = {22'h000000, irq_mask_reg};
            default: rdata_next = 24'h000000;
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 24'h000000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   // All data outputs come straight from flip-flops.
   assign bus_rdata = rdata_reg;
   assign equal_output_pin = out_reg;
   // Level interrupt while any unmasked status bit is set.
   assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

`default_nettype wire

//--- dv/ecc_chk.sv
// Port assertions for the encoder capture/compare block.
// Assumes shadows of the control, compare and trigger words rebuilt from bus writes.
`timescale 1ns/1ns
`default_nettype none
module ecc_chk
   import ecc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ecc_bus_req_t bus_req,
   input wire logic [23:0] bus_rdata,
   input wire ecc_enc_in_t enc_in,
   input wire logic equal_output_pin,
   input wire logic irq
);
   logic [2:0] ctl_reg;
   logic [23:0] cmp_reg;
   logic [3:0] trg_reg;
   logic hit, rd0, rd3;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadows follow the writes that the design accepts on the same edge.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= 3'h0;
         cmp_reg <= 24'h0;
         trg_reg <= 4'h0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == 16'hc000) ctl_reg <= bus_req.wdata[13:11];
         if (bus_req.addr == 16'hc003) cmp_reg <= bus_req.wdata;
         if (bus_req.addr == 16'hc004) trg_reg <= bus_req.wdata[3:0];
      end
   end
   // Decoded strobes and the raw equality, for the properties below.
   assign hit = enc_in.count == cmp_reg;
   assign rd0 = bus_req.rd && bus_req.addr == 16'hc000;
   assign rd3 = bus_req.rd && bus_req.addr == 16'hc003;
   AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 24'h0)
      else $error("read data not idle");
   AST_UNMAPPED: assert property (bus_req.rd && !(bus_req.addr inside {16'hc000,
      [16'hc003:16'hc007]}) |=> bus_rdata == 24'h0) else $error("unmapped read not zero");
   AST_CTRL_RB: assert property (rd0 |=> bus_rdata[13:11] == $past(ctl_reg))
      else $error("control bits read back wrong");
   AST_EQ_FLAG: assert property (rd0 && !ctl_reg[0] |=> bus_rdata[16] == $past(hit))
      else $error("compare status wrong");
   AST_TRANSP: assert property (!$past(ctl_reg[0]) |-> equal_output_pin ==
      ($past(hit && ctl_reg[1]) ^ $past(ctl_reg[2]))) else $error("transparent pin wrong");
   AST_OFF: assert property ($past(!ctl_reg[1]) |-> equal_output_pin == $past(ctl_reg[2]))
      else $error("disabled pin not at inactive level");
   AST_LATCH_HOLD: assert property ((ctl_reg == 3'h3)[*3] ##0 $past(equal_output_pin)
      |-> equal_output_pin) else $error("latched pin dropped");
   AST_SW_DONE: assert property (bus_req.wr && bus_req.addr == 16'hc007 &&
      bus_req.wdata[0] && trg_reg == 4'h0 ##1 rd0 |=> bus_rdata[17]) else $error("no done");
   AST_CAP_CLR: assert property (rd3 && trg_reg == 4'h0 ##1 rd0 |=> !bus_rdata[17])
      else $error("done not cleared by capture read");
endmodule
bind ecc_capture_compare ecc_chk u_ecc_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .enc_in(enc_in), .equal_output_pin(equal_output_pin), .irq(irq));
`default_nettype wire

//--- dv/ecc_enc_model.sv
// Encoder side model: a counter moving by a step each clock, plus index and flags.
// Assumes the bench sets the step and the index and flag levels.
`timescale 1ns/1ns
`default_nettype none
module ecc_enc_model
   import ecc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [23:0] step,
   input wire logic index,
   input wire logic [3:0] flags,
   output var ecc_enc_in_t enc
);
   logic [23:0] cnt_reg;
   // The count restarts at zero on reset and is never offset, as a real counter.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 24'h0;
      end else begin
         cnt_reg <= cnt_reg + step;
      end
   end
   assign enc = {cnt_reg, index, flags};
endmodule
`default_nettype wire

//--- dv/ecc_capture_compare_tb.sv
// Self-checking bench for the encoder capture/compare block.
// Assumes the encoder model drives the counter; the bench drives index, flags and bus.
`timescale 1ns/1ns
`default_nettype none
module ecc_capture_compare_tb;
   import ecc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic idx = 1'b0;
   logic pe = 1'b0;
   logic pin, irq;
   logic [3:0] flg = 4'h0;
   logic [23:0] rdata, exp, pe_e, pe_m;
   logic [23:0] step = 24'h1;
   logic [23:0] seed = 24'd47954;
   ecc_bus_req_t req = '0;
   ecc_enc_in_t enc;
   int n_mismatch = 0;
   int cmp_count = 0;
   int k, hits;
   ecc_enc_model u_ecc_enc_model (.clk(clk), .rst_n(rst_n), .step(step), .index(idx),
      .flags(flg), .enc(enc));
   ecc_capture_compare u_ecc_capture_compare (.clk(clk), .rst_n(rst_n), .bus_req(req),
      .bus_rdata(rdata), .enc_in(enc), .equal_output_pin(pin), .irq(irq));
   // Clock at 50 MHz.
   initial forever #10 clk = ~clk;
   function automatic logic [23:0] lfsr(input logic [23:0] v);
      return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
   endfunction
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One bus cycle; a read's expectation is checked in the following cycle.
   task automatic bus(input logic w, input logic r, input logic [15:0] a,
      input logic [23:0] d, input logic [23:0] m = 24'h0);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
      @(posedge clk);
      pe <= r;
      pe_e <= d;
      pe_m <= m;
   endtask
   // Read data stand for one cycle only, so they are looked at mid-cycle.
   always @(negedge clk) begin
      if (pe) chk("read data", pe_e & pe_m, rdata & pe_m);
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // A hang is cut off long after the few hundred cycles the run needs.
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, 1, 16'hc000, 24'h010000, 24'hffffff);
      bus(0, 1, 16'hc001, 24'h0, 24'hffffff);
      bus(1, 0, 16'hc003, 24'h800000);
      bus(0, 1, 16'hc003, 24'h0, 24'hffffff);
      bus(1, 0, 16'hc006, 24'h2);
      for (k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         bus(1, 0, 16'hc000, {10'h0, k[1], 1'b1, k[0], 11'h0});
         bus(1, 0, 16'hc003, enc.count + 24'h8 + {21'h0, seed[2:0]});
         bus(0, 0, 16'h0, 24'h0);
         hits = 0;
         repeat (30) begin
            @(negedge clk);
            hits += int'(pin === !k[1]);
         end
         if (k[0]) chk("latched pin", 24'(!k[1]), 24'(pin));
         else chk("pulse count", 24'd1, 24'(hits));
         chk("compare irq", 24'h1, {23'h0, irq});
         @(posedge clk);
         bus(1, 0, 16'hc005, 24'h3);
         bus(1, 0, 16'hc000, {10'h0, k[1], 1'b1, 1'b0, 11'h0});
         bus(1, 0, 16'hc000, {10'h0, k[1], 1'b1, 1'b1, 11'h0});
         bus(0, 0, 16'h0, 24'h0);
         @(negedge clk);
         chk("cleared pin", 24'(k[1]), 24'(pin));
         chk("irq cleared", 24'h0, {23'h0, irq});
         @(posedge clk);
      end
      bus(1, 0, 16'hc006, 24'h1);
      bus(1, 0, 16'hc004, 24'h1);
      idx <= 1'b1;
      exp = enc.count + step;
      repeat (3) @(posedge clk);
      idx <= 1'b0;
      @(posedge clk);
      idx <= 1'b1;
      @(negedge clk);
      chk("capture irq", 24'h1, {23'h0, irq});
      @(posedge clk);
      bus(0, 1, 16'hc000, 24'h020000, 24'h020000);
      bus(0, 1, 16'hc003, exp, 24'hffffff);
      bus(0, 1, 16'hc000, 24'h0, 24'h020000);
      bus(1, 0, 16'hc004, {18'h0, seed[5:4], 4'h3});
      bus(0, 0, 16'h0, 24'h0);
      flg <= 4'hf ^ (4'h1 << seed[5:4]);
      repeat (3) @(posedge clk);
      flg <= 4'hf;
      exp = enc.count + step;
      repeat (3) @(posedge clk);
      bus(0, 1, 16'hc003, exp, 24'hffffff);
      bus(1, 0, 16'hc004, 24'h0);
      exp = enc.count + step;
      bus(1, 0, 16'hc007, 24'h1);
      bus(0, 1, 16'hc000, 24'h020000, 24'h020000);
      bus(0, 1, 16'hc003, exp, 24'hffffff);
      bus(0, 1, 16'hc000, 24'h0, 24'h020000);
      bus(0, 0, 16'h0, 24'h0);
      @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
